// >>> ufrt_frame_timer.sv
// Frame timer: interval, remaining and frame number registers with the
// frame remaining counter and largest-packet budget counter.
// Assumes bit ticks, operational level and transfer strobes are synchronous.
module ufrt_frame_timer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // Bus timing
  input  wire logic        i_bit_tick,
  input  wire logic        i_operational,
  output logic             o_sof,
  output logic      [15:0] o_frame_count,
  // Transaction budget
  input  wire logic        i_xfer_bit,
  input  wire logic        i_txn_req,
  input  wire logic [14:0] i_txn_bits,
  output logic             o_txn_ok,
  output logic             o_txn_refused
);
  // ****************************************
  // Register state
  // ****************************************
  logic [13:0] ivl_r,   ivl_nxt;
  logic [14:0] fs_r,    fs_nxt;
  logic        itog_r,  itog_nxt;
  logic        rtog_r,  rtog_nxt;
  logic [15:0] fcnt_r,  fcnt_nxt;
  logic        op_r,    op_nxt;
  logic        sof_r,   sof_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ok_r,    ok_nxt;
  logic        ref_r,   ref_nxt;
  logic [13:0] rem_cnt;
  logic        rem_zero;
  logic [14:0] lp_cnt;
  logic        wr_int;
  logic        wr_rem;
  logic        wr_num;
  logic        op_rise;
  logic        frame_end;
  logic        frame_start;
  logic        rem_load;
  logic [13:0] rem_val;

  assign wr_int      = i_reg_wr && (i_reg_addr == ufrt_pkg::OFS_INTERVAL);
  assign wr_rem      = i_reg_wr && (i_reg_addr == ufrt_pkg::OFS_REMAINING);
  assign wr_num      = i_reg_wr && (i_reg_addr == ufrt_pkg::OFS_NUMBER);
  assign op_rise     = i_operational && !op_r;
  assign frame_end   = i_bit_tick && rem_zero && !op_rise && !wr_rem;
  assign frame_start = frame_end || op_rise;

  // ****************************************
  // Frame remaining counter and largest-packet budget counter
  // ****************************************
  always_comb begin
    rem_load = 1'b0;
    rem_val  = ivl_r;
    if (op_rise) begin
      rem_load = 1'b1;
    end else if (wr_rem) begin
      rem_load = 1'b1;
      rem_val  = i_reg_wdata[ufrt_pkg::IVL_LSB +: ufrt_pkg::IVL_W];
    end else if (frame_end) begin
      rem_load = 1'b1;
    end
  end

  ufrt_down_cnt #(.W(ufrt_pkg::IVL_W)) u_rem_cnt (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_load     (rem_load),
    .i_load_val (rem_val),
    .i_dec      (i_bit_tick),
    .o_count    (rem_cnt),
    .o_zero     (rem_zero)
  );

  ufrt_down_cnt #(.W(ufrt_pkg::FS_W)) u_lp_cnt (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_load     (frame_start),
    .i_load_val (fs_r),
    .i_dec      (i_xfer_bit),
    .o_count    (lp_cnt),
    .o_zero     ()
  );

  // ****************************************
  // Registers and status
  // ****************************************
  always_comb begin
    ivl_nxt   = ivl_r;
    fs_nxt    = fs_r;
    itog_nxt  = itog_r;
    rtog_nxt  = rtog_r;
    fcnt_nxt  = fcnt_r;
    op_nxt    = i_operational;
    sof_nxt   = frame_start;
    rdata_nxt = rdata_r;
    ok_nxt    = 1'b0;
    ref_nxt   = 1'b0;
    if (wr_int) begin
      ivl_nxt  = i_reg_wdata[ufrt_pkg::IVL_LSB +: ufrt_pkg::IVL_W];
      fs_nxt   = i_reg_wdata[ufrt_pkg::FS_LSB +: ufrt_pkg::FS_W];
      itog_nxt = i_reg_wdata[ufrt_pkg::TOG_BIT];
    end
    if (wr_rem) begin
      rtog_nxt = i_reg_wdata[ufrt_pkg::TOG_BIT];
    end
    if (frame_end) begin
      rtog_nxt = itog_r;
    end
    if (frame_start) begin
      fcnt_nxt = fcnt_r + ufrt_pkg::FCNT_ONE;
    end else if (wr_num) begin
      fcnt_nxt = i_reg_wdata[ufrt_pkg::FCNT_W-1:0];
    end
    if (i_txn_req && !frame_start) begin
      ok_nxt  = (i_txn_bits <= lp_cnt);
      ref_nxt = (i_txn_bits >  lp_cnt);
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        ufrt_pkg::OFS_INTERVAL:  rdata_nxt = {itog_r, fs_r, 2'h0, ivl_r};
        ufrt_pkg::OFS_REMAINING: rdata_nxt = {rtog_r, 17'h00000, rem_cnt};
        ufrt_pkg::OFS_NUMBER:    rdata_nxt = {16'h0000, fcnt_r};
        default:                 rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ivl_r   <= ufrt_pkg::IVL_RST;
      fs_r    <= ufrt_pkg::FS_RST;
      itog_r  <= 1'b0;
      rtog_r  <= 1'b0;
      fcnt_r  <= ufrt_pkg::FCNT_RST;
      op_r    <= 1'b0;
      sof_r   <= 1'b0;
      rdata_r <= 32'h00000000;
      ok_r    <= 1'b0;
      ref_r   <= 1'b0;
    end else begin
      ivl_r   <= ivl_nxt;
      fs_r    <= fs_nxt;
      itog_r  <= itog_nxt;
      rtog_r  <= rtog_nxt;
      fcnt_r  <= fcnt_nxt;
      op_r    <= op_nxt;
      sof_r   <= sof_nxt;
      rdata_r <= rdata_nxt;
      ok_r    <= ok_nxt;
      ref_r   <= ref_nxt;
    end
  end

  assign o_reg_rdata   = rdata_r;
  assign o_sof         = sof_r;
  assign o_frame_count = fcnt_r;
  assign o_txn_ok      = ok_r;
  assign o_txn_refused = ref_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_frame_end;
    i_bit_tick && rem_zero && !op_rise && !wr_rem;
  endsequence

  sequence seq_count_step;
    i_bit_tick && !rem_zero && !op_rise && !wr_rem;
  endsequence

  reset_interval_a: assert property (@(posedge i_clk)
    i_rst |=> (ivl_r == ufrt_pkg::IVL_RST) && (rem_cnt == 14'h0000))
    else $error("interval not nominal after reset");

  count_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_count_step |=> rem_cnt == $past(rem_cnt) - 14'h0001)
    else $error("remaining counter did not step down");

  zero_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_frame_end |=> (rem_cnt == $past(ivl_r)) && o_sof)
    else $error("remaining counter not reloaded at zero");

  toggle_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_frame_end |=> rtog_r == $past(itog_r))
    else $error("remaining toggle not copied");

  op_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(i_operational) |=> (rem_cnt == $past(ivl_r)) && (fcnt_r == $past(fcnt_r) + 16'h0001))
    else $error("operational entry did not reload");

  number_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_frame_end |=> (fcnt_r == $past(fcnt_r) + 16'h0001) && o_frame_count == fcnt_r)
    else $error("frame number did not advance");

  budget_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_start |=> lp_cnt == $past(fs_r))
    else $error("budget counter not loaded at frame start");

  oversize_refuse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_txn_req && !frame_start && (i_txn_bits > lp_cnt)) |=> o_txn_refused && !o_txn_ok)
    else $error("oversize transaction not refused");

  sof_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (seq_frame_end ##1 (!i_bit_tick && !wr_rem && !i_operational)[*2]) |-> rem_cnt == ivl_r
      || $past(wr_int, 2) || $past(wr_int))
    else $error("remaining counter drifted after reload");
endmodule // ufrt_frame_timer

// >>> ufrt_pkg.sv
// Constants for the USB host frame timer: register offsets, field layout,
// reset values. Assumes a byte-addressed register port on i_clk; bit times come as i_bit_tick strobes.
// Functional notes
// - Load largest-packet counter at every frame start.
// - Counter bounds bits per single transaction.
// - Interval field sets bit times between SOFs.
// - Reset returns interval to 11999 bit times.
// - Fourteen-bit remaining counter decrements each bit time.
// - At zero, reload remaining from interval.
// - At zero, copy interval toggle to remaining toggle.
// - Operational entry reloads remaining from interval.
// - Sixteen-bit frame number counter as time reference.
// - Frame number increments on reload, wraps to zero.
package ufrt_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_INTERVAL  = 8'h34;
  localparam logic [7:0]  OFS_REMAINING = 8'h38;
  localparam logic [7:0]  OFS_NUMBER    = 8'h3C;
  // ****************************************
  // Field layout
  // ****************************************
  localparam int          IVL_W         = 14;
  localparam int          FS_W          = 15;
  localparam int          FCNT_W        = 16;
  localparam int          IVL_LSB       = 0;
  localparam int          FS_LSB        = 16;
  localparam int          TOG_BIT       = 31;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [13:0] IVL_RST       = 14'h2EDF;
  localparam logic [14:0] FS_RST        = 15'h0000;
  localparam logic [15:0] FCNT_RST      = 16'h0000;
  localparam logic [15:0] FCNT_ONE      = 16'h0001;
endpackage

// >>> ufrt_down_cnt.sv
// Loadable down counter that stops at zero.
// Assumes load and decrement come from logic on the same clock.
module ufrt_down_cnt #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  input  wire logic         i_dec,
  // State
  output logic      [W-1:0] o_count,
  output logic              o_zero
);
  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_load_val;
    end else if (i_dec && (cnt_r != '0)) begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_count = cnt_r;
  assign o_zero  = (cnt_r == '0);
endmodule // ufrt_down_cnt

// >>> tb_ufrt_frame_timer.sv
// Self-checking bench for the frame timer: register reads and writes,
// bit ticks, operational entry and transaction budget requests.
// Assumes one 20 MHz clock and the design's synchronous active-high reset.
module tb_ufrt_frame_timer;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals
  // ****************************************
  logic        i_clk, i_rst, i_reg_wr, i_reg_rd, i_bit_tick, i_operational;
  logic        i_xfer_bit, i_txn_req, o_sof, o_txn_ok, o_txn_refused;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [15:0] o_frame_count;
  logic [14:0] i_txn_bits;
  logic [31:0] saved_ivl;
  int          err_count, cmp_count, cyc, sof_n;

  ufrt_frame_timer u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_bit_tick(i_bit_tick), .i_operational(i_operational), .o_sof(o_sof),
    .o_frame_count(o_frame_count), .i_xfer_bit(i_xfer_bit), .i_txn_req(i_txn_req),
    .i_txn_bits(i_txn_bits), .o_txn_ok(o_txn_ok), .o_txn_refused(o_txn_refused)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), o_reg_rdata, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_bit_tick <= 1'b1;
      @(posedge i_clk);
      i_bit_tick <= 1'b0;
    end
  endtask

  task automatic txn(input logic [14:0] b, input logic ok);
    @(posedge i_clk);
    i_txn_req  <= 1'b1;
    i_txn_bits <= b;
    @(posedge i_clk);
    i_txn_req  <= 1'b0;
    #1;
    chk("txn ok", {31'h0, o_txn_ok}, {31'h0, ok});
    chk("txn refused", {31'h0, o_txn_refused}, {31'h0, ~ok});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge i_clk) begin
    if (o_sof === 1'b1) sof_n++;
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, i_bit_tick, i_operational, i_xfer_bit, i_txn_req} = 7'h40;
    i_reg_addr  = 8'h00;
    i_reg_wdata = 32'h00000000;
    i_txn_bits  = 15'h0000;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h34, 32'h00002EDF);
    rd(8'h38, 32'h00000000);
    rd(8'h3C, 32'h00000000);
    rd(8'h40, 32'h00000000);
    $display("test reset values done");
    wr(8'h34, 32'h80140002);
    rd(8'h34, 32'h80140002);
    tick(1);
    rd(8'h38, 32'h80000002);
    rd(8'h3C, 32'h00000001);
    tick(1);
    rd(8'h38, 32'h80000001);
    $display("test reload done");
    txn(15'h0014, 1'b1);
    txn(15'h0015, 1'b0);
    repeat (5) begin
      @(posedge i_clk);
      i_xfer_bit <= 1'b1;
      @(posedge i_clk);
      i_xfer_bit <= 1'b0;
    end
    txn(15'h0010, 1'b0);
    txn(15'h000F, 1'b1);
    $display("test budget done");
    sof_n = 0;
    tick(9);
    repeat (3) @(posedge i_clk);
    #1;
    chk("sof count", sof_n, 32'h3);
    chk("frame count", {16'h0, o_frame_count}, 32'h4);
    rd(8'h38, 32'h80000001);
    $display("test frame spacing done");
    wr(8'h34, 32'h00140002);
    sof_n = 0;
    @(posedge i_clk);
    i_operational <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(8'h38, 32'h80000002);
    rd(8'h3C, 32'h00000005);
    chk("sof on entry", sof_n, 32'h1);
    tick(3);
    rd(8'h38, 32'h00000002);
    $display("test operational entry done");
    wr(8'h3C, 32'h0000FFFF);
    tick(3);
    rd(8'h3C, 32'h00000000);
    chk("extended frame", {16'h0001, o_reg_rdata[15:0]}, 32'h00010000);
    wr(8'h38, 32'h80003FFF);
    rd(8'h38, 32'h80003FFF);
    wr(8'h34, 32'hFFFF3FFF);
    rd(8'h34, 32'hFFFF3FFF);
    $display("test wrap and reserved done");
    rd(8'h34, 32'hFFFF3FFF);
    saved_ivl = o_reg_rdata;
    @(posedge i_clk);
    i_rst         <= 1'b1;
    i_operational <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h34, 32'h00002EDF);
    rd(8'h38, 32'h00000000);
    rd(8'h3C, 32'h00000000);
    wr(8'h34, saved_ivl);
    rd(8'h34, 32'hFFFF3FFF);
    $display("test reset and restore done");
    summarize();
  end
endmodule // tb_ufrt_frame_timer
